// *** hw/aer_pkg.sv ***
// Package for the front-end event routing block: register map, field
// layouts, reset values and timing constants.
// Assumes a 10 MHz system clock and a plain strobe register port.
package aer_pkg;

	// ********************************************************
	// Sizes
	// ********************************************************
	localparam int NUM_GC   = 4;   // General comparators
	localparam int NUM_PH   = 3;   // Phase comparators
	localparam int NUM_PC   = 6;   // Protection comparators, two per amplifier
	localparam int NUM_IO   = 10;  // Front-end I/O pins
	localparam int NUM_DB   = 7;   // Digital matrix lines
	localparam int NUM_ADC  = 16;  // Pre-selector inputs
	localparam int FIRST_IRQ_IO = 6;
	localparam int NUM_IRQ_IO   = 4;

	// ********************************************************
	// Register offsets (byte addresses)
	// ********************************************************
	localparam logic [7:0] REG_GC_CFG   = 8'h00; // ref sel, invert, route
	localparam logic [7:0] REG_GC_MASK  = 8'h04; // rise[3:0], fall[7:4]
	localparam logic [7:0] REG_PH_CFG   = 8'h08; // ref sel[5:0], invert[8:6]
	localparam logic [7:0] REG_PC_MASK  = 8'h0c; // main[5:0] ev1[13:8] ev2[21:16]
	localparam logic [7:0] REG_FAST_DAC = 8'h10;
	localparam logic [7:0] REG_LIM_DAC  = 8'h14;
	localparam logic [7:0] REG_IO_DIR   = 8'h18; // 1 = open-drain output
	localparam logic [7:0] REG_IO_POL   = 8'h1c; // 1 = active low
	localparam logic [7:0] REG_IO_ROUTE = 8'h20; // 1 = matrix, 0 = data bit; line index in REG_IO_LINE
	localparam logic [7:0] REG_IO_LINE  = 8'h24; // 3-bit line idx per pin
	localparam logic [7:0] REG_IO_OUT   = 8'h28;
	localparam logic [7:0] REG_IO_MASK  = 8'h2c; // rise[3:0], fall[7:4]
	localparam logic [7:0] REG_DATA_IN  = 8'h30; // read only status
	localparam logic [7:0] REG_PEND     = 8'h34; // write one to clear
	localparam logic [7:0] REG_CTRL     = 8'h38; // misc control
	localparam logic [7:0] REG_ADC      = 8'h3c; // sel, auto, scan mask

	// CTRL fields
	localparam int CTRL_I2_EV1  = 0;
	localparam int CTRL_BTN_EN  = 1;
	localparam int CTRL_HIB_REQ = 2;
	localparam int CTRL_AB2_DAC = 3;
	localparam int CTRL_AB3_DAC = 4;

	// Reset values
	localparam logic [31:0] RST_ZERO = 32'h0000_0000;

	// ********************************************************
	// Timing
	// ********************************************************
	localparam longint CLK_HZ         = 10_000_000;
	localparam longint LONG_PRESS_S   = 8;
	localparam longint LONG_PRESS_CYC = LONG_PRESS_S * CLK_HZ;

	// Reference choice of a comparator
	typedef enum logic [1:0] {
		AER_REF_THRESHOLD = 2'b00,
		AER_REF_MATRIX    = 2'b01,
		AER_REF_PHASE     = 2'b11
	} aer_ref_t;

	// Register port request
	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} aer_req_t;

	// Protection event pair
	typedef struct packed {
		logic two;
		logic one;
	} aer_prot_t;

endpackage

// *** hw/aer_top.sv ***
// Front-end event routing: comparator and pin routing, edge interrupts,
// protection events, push button, ADC pre-selector and DAC codes.
// Assumes comparators and pins are asynchronous; one 10 MHz clock.
// Behaviour
// - General comparator reference: threshold reference or analog matrix line.
// - General comparator output inverted optionally, routed to data bit or matrix.
// - Unmasked rising or falling general comparator edge raises second interrupt.
// - Second interrupt can also activate protection event one.
// - Phase comparator reference: threshold, matrix line or phase average.
// - Phase result, optionally inverted, goes to data bit and position selector.
// - Two protection comparators per amplifier, each readable as status.
// - Fast protection threshold from 8-bit DAC code, 2.5V full scale.
// - Limit protection threshold from 10-bit DAC code, 2.5V full scale.
// - Each protection comparator has a main interrupt mask bit.
// - Each protection comparator has separate event one and event two masks.
// - Protection events go straight to the gate-driver protection logic.
// - Front-end pin: input or open-drain output, via data bit or matrix.
// - Front-end pin polarity active high after reset, settable active low.
// - Pins 6 to 9 have edge masks; unmasked edges raise second interrupt.
// - Enabled push button gives press detect, hibernate request and wake.
// - Button held low over 8s in normal operation resets the processor.
// - ADC pre-selector picks one of 16 inputs.
// - Pre-selector driven by software select or sequencer scan.
// - Analog matrix lines 2 and 3 carry the DAC outputs when selected.
// - Digital matrix has 7 bidirectional lines for pins or comparators.
//
// The implementer's own choices: the register addresses and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
module aer_top
	import aer_pkg::*;
#(
	parameter longint LONG_PRESS = LONG_PRESS_CYC
) (
	input  wire logic                REF_CLK,        // System clock
	input  wire logic                RST_N,          // Async reset, active low
	input  wire logic [7:0]          REG_ADDR,       // Register byte address
	input  wire logic [31:0]         REG_WDATA,      // Write data
	input  wire logic                REG_WR,         // Write strobe
	input  wire logic                REG_RD,         // Read strobe
	output logic      [31:0]         REG_RDATA,      // Read data, cycle after strobe
	input  wire logic [NUM_GC-1:0]   GC_RAW,         // General comparator outputs
	output logic      [2*NUM_GC-1:0] GC_REF_SEL,     // Reference select per comparator
	input  wire logic [NUM_PH-1:0]   PH_RAW,         // Phase comparator outputs
	output logic      [2*NUM_PH-1:0] PH_REF_SEL,     // Reference select per comparator
	output logic      [NUM_PH-1:0]   PH_POS,         // To position selector
	input  wire logic [NUM_PC-1:0]   PC_RAW,         // Protection comparator outputs
	output logic      [7:0]          FAST_DAC_CODE,  // Fast protection DAC code
	output logic      [9:0]          LIM_DAC_CODE,   // Limit protection DAC code
	output logic                     AB2_DAC_EN,     // Fast DAC onto matrix line 2
	output logic                     AB3_DAC_EN,     // Limit DAC onto matrix line 3
	input  wire logic [NUM_IO-1:0]   IO_I,           // Pin levels
	output logic      [NUM_IO-1:0]   IO_O,           // Pin drive value (always 0)
	output logic      [NUM_IO-1:0]   IO_OE,          // Pin pull-low enable
	input  wire logic [NUM_DB-1:0]   DB_I,           // Matrix line levels
	output logic      [NUM_DB-1:0]   DB_O,           // Matrix line drive value
	output logic      [NUM_DB-1:0]   DB_OE,          // Matrix line drive enable
	input  wire logic                BTN_N,          // Push button, active low
	input  wire logic                HIBERNATE,      // System in hibernate
	output logic                     BTN_WAKE,       // Wake request
	output logic                     HIB_REQ,        // Hibernate request
	output logic                     CPU_RESET,      // Long-press processor reset
	input  wire logic                SEQ_STEP,       // Sequencer scan advance
	output logic      [3:0]          ADC_SEL,        // Pre-selector input
	output logic                     MAIN_IRQ,       // Main interrupt
	output logic                     SECOND_IRQ,     // Second interrupt
	output aer_prot_t                PROT_EV         // Protection events
);

	// ********************************************************
	// Elaboration check
	// ********************************************************
	if (LONG_PRESS < 2) begin : g_bad
		$error("LONG_PRESS too small");
	end

	// ********************************************************
	// Registers
	// ********************************************************
	logic [31:0] gc_cfg, gc_mask, ph_cfg, pc_mask, io_dir, io_pol;
	logic [31:0] io_route, io_line, io_out, io_mask, ctrl, adc_cfg;
	logic [7:0]  fast_dac;
	logic [9:0]  lim_dac;
	logic [31:0] pend;
	aer_req_t    req;

	assign req = '{addr: REG_ADDR, wdata: REG_WDATA, wr: REG_WR, rd: REG_RD};

	// Address match shared by write and read paths
	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction

	// Software registers, plain write
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			gc_cfg   <= RST_ZERO;
			gc_mask  <= RST_ZERO;
			ph_cfg   <= RST_ZERO;
			pc_mask  <= RST_ZERO;
			io_dir   <= RST_ZERO;
			io_pol   <= RST_ZERO;
			io_route <= RST_ZERO;
			io_line  <= RST_ZERO;
			io_out   <= RST_ZERO;
			io_mask  <= RST_ZERO;
			ctrl     <= RST_ZERO;
			adc_cfg  <= RST_ZERO;
			fast_dac <= 8'h00;
			lim_dac  <= 10'h000;
		end else if (req.wr) begin
			if (hit(req.addr, REG_GC_CFG))        gc_cfg   <= req.wdata;
			else if (hit(req.addr, REG_GC_MASK))  gc_mask  <= req.wdata;
			else if (hit(req.addr, REG_PH_CFG))   ph_cfg   <= req.wdata;
			else if (hit(req.addr, REG_PC_MASK))  pc_mask  <= req.wdata;
			else if (hit(req.addr, REG_FAST_DAC)) fast_dac <= req.wdata[7:0];
			else if (hit(req.addr, REG_LIM_DAC))  lim_dac  <= req.wdata[9:0];
			else if (hit(req.addr, REG_IO_DIR))   io_dir   <= req.wdata;
			else if (hit(req.addr, REG_IO_POL))   io_pol   <= req.wdata;
			else if (hit(req.addr, REG_IO_ROUTE)) io_route <= req.wdata;
			else if (hit(req.addr, REG_IO_LINE))  io_line  <= req.wdata;
			else if (hit(req.addr, REG_IO_OUT))   io_out   <= req.wdata;
			else if (hit(req.addr, REG_IO_MASK))  io_mask  <= req.wdata;
			else if (hit(req.addr, REG_CTRL))     ctrl     <= req.wdata;
			else if (hit(req.addr, REG_ADC))      adc_cfg  <= req.wdata;
		end
	end

	// ********************************************************
	// Input synchronisers
	// ********************************************************
	localparam int NSYNC = NUM_GC + NUM_PH + NUM_PC + NUM_IO + NUM_DB + 1;
	logic [NSYNC-1:0] sync_a, sync_b, sync_c;

	// Two flops per input, third stage only for edge history
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			// Idle levels: button pulled up, the rest low, so release makes no edge
			sync_a <= {1'b1, {(NSYNC-1){1'b0}}};
			sync_b <= {1'b1, {(NSYNC-1){1'b0}}};
			sync_c <= {1'b1, {(NSYNC-1){1'b0}}};
		end else begin
			sync_a <= {BTN_N, DB_I, IO_I, PC_RAW, PH_RAW, GC_RAW};
			sync_b <= sync_a;
			sync_c <= sync_b;
		end
	end

	wire [NUM_GC-1:0] gc_s  = sync_b[NUM_GC-1:0];
	wire [NUM_PH-1:0] ph_s  = sync_b[NUM_GC +: NUM_PH];
	wire [NUM_PC-1:0] pc_s  = sync_b[NUM_GC+NUM_PH +: NUM_PC];
	wire [NUM_IO-1:0] io_s  = sync_b[NUM_GC+NUM_PH+NUM_PC +: NUM_IO];
	wire [NUM_DB-1:0] db_s  = sync_b[NUM_GC+NUM_PH+NUM_PC+NUM_IO +: NUM_DB];
	wire              btn_s = sync_b[NSYNC-1];

	// ********************************************************
	// Comparator routing
	// ********************************************************
	// Gc cfg: [2i+1:2i] ref, [8+i] invert, [12+i] to matrix, [16+3i+:3] line
	wire [NUM_GC-1:0] gc_val  = gc_s ^ gc_cfg[8 +: NUM_GC];
	wire [NUM_GC-1:0] gc_prev = sync_c[NUM_GC-1:0] ^ gc_cfg[8 +: NUM_GC];
	wire [NUM_GC-1:0] gc_data = gc_val & ~gc_cfg[12 +: NUM_GC];
	wire [NUM_PH-1:0] ph_val  = ph_s ^ ph_cfg[8:6];

	// Gc reference may not pick the phase average
	genvar g;
	generate
		for (g = 0; g < NUM_GC; g++) begin : g_gcref
			assign GC_REF_SEL[2*g +: 2] = {1'b0, gc_cfg[2*g]};
		end
	endgenerate
	assign PH_REF_SEL = ph_cfg[5:0];
	assign PH_POS     = ph_val;
	assign FAST_DAC_CODE = fast_dac;
	assign LIM_DAC_CODE  = lim_dac;
	assign AB2_DAC_EN    = ctrl[CTRL_AB2_DAC];
	assign AB3_DAC_EN    = ctrl[CTRL_AB3_DAC];

	// ********************************************************
	// Pins and digital matrix
	// ********************************************************
	// Polarity applied both ways so software sees asserted as 1
	wire [NUM_IO-1:0] io_log = io_s ^ io_pol[NUM_IO-1:0];
	wire [NUM_IO-1:0] io_prev = sync_c[NUM_GC+NUM_PH+NUM_PC +: NUM_IO] ^ io_pol[NUM_IO-1:0];
	logic [NUM_IO-1:0] io_drv;
	logic [NUM_DB-1:0] db_drv, db_en;

	// Pick pin source per pin, and matrix drivers per line
	always_comb begin
		db_drv = '0;
		db_en  = '0;
		for (int i = 0; i < NUM_IO; i++) begin
			io_drv[i] = io_route[i] ? db_s[io_line[3*i +: 3] % NUM_DB] : io_out[i];
			if (io_route[i] && !io_dir[i]) begin
				db_en[io_line[3*i +: 3] % NUM_DB]  = 1'b1;
				db_drv[io_line[3*i +: 3] % NUM_DB] = io_log[i];
			end
		end
		for (int i = 0; i < NUM_GC; i++) begin
			if (gc_cfg[12+i]) begin
				db_en[gc_cfg[16+3*i +: 3] % NUM_DB]  = 1'b1;
				db_drv[gc_cfg[16+3*i +: 3] % NUM_DB] = gc_val[i];
			end
		end
	end

	// Open drain: only ever pull low, when asserted level maps to low
	assign IO_O  = '0;
	assign IO_OE = io_dir[NUM_IO-1:0] & ~(io_drv ^ io_pol[NUM_IO-1:0]);
	assign DB_O  = db_drv;
	assign DB_OE = db_en;

	// ********************************************************
	// Pending flags and interrupts
	// ********************************************************
	// Pend: [3:0] gc rise, [7:4] gc fall, [11:8] pin rise, [15:12] pin fall,
	// [21:16] protection, [24] button press
	wire [NUM_IRQ_IO-1:0] ip  = io_log[FIRST_IRQ_IO +: NUM_IRQ_IO];
	wire [NUM_IRQ_IO-1:0] ipp = io_prev[FIRST_IRQ_IO +: NUM_IRQ_IO];
	wire btn_fall = sync_c[NSYNC-1] & ~btn_s & ctrl[CTRL_BTN_EN];
	wire [31:0] ev;
	assign ev = {7'h00, btn_fall, 2'b00, pc_s,
		~ip & ipp, ip & ~ipp,
		~gc_val & gc_prev, gc_val & ~gc_prev};
	wire pend_clr = req.wr && hit(req.addr, REG_PEND);

	// Set wins over a clear in the same cycle
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) pend <= RST_ZERO;
		else pend <= (pend & ~(pend_clr ? req.wdata : 32'h0)) | ev;
	end

	wire [15:0] mask2 = {io_mask[7:4], io_mask[3:0], gc_mask[7:4], gc_mask[3:0]};
	wire sec = |(pend[15:0] & mask2);
	assign SECOND_IRQ = sec;
	assign MAIN_IRQ   = |(pend[21:16] & pc_mask[5:0]) | pend[24];
	// Events use the live comparator level so protection stays fast
	assign PROT_EV.one = |(pc_s & pc_mask[13:8]) | (sec & ctrl[CTRL_I2_EV1]);
	assign PROT_EV.two = |(pc_s & pc_mask[21:16]);

	// ********************************************************
	// Push button
	// ********************************************************
	logic [39:0] press_cnt;
	logic        reset_out;

	// Long-press counter runs only outside hibernate
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			press_cnt <= 40'h0;
			reset_out <= 1'b0;
		end else if (btn_s || HIBERNATE) begin
			press_cnt <= 40'h0;
			reset_out <= 1'b0;
		end else if (press_cnt >= 40'(LONG_PRESS)) begin
			reset_out <= 1'b1;
		end else begin
			press_cnt <= press_cnt + 40'h1;
		end
	end
	assign CPU_RESET = reset_out;
	assign HIB_REQ   = ctrl[CTRL_HIB_REQ] & ctrl[CTRL_BTN_EN];
	assign BTN_WAKE  = HIBERNATE & ctrl[CTRL_BTN_EN] & ~btn_s;

	// ********************************************************
	// ADC pre-selector
	// ********************************************************
	// Adc cfg: [3:0] direct select, [4] auto scan, [31:16] scan mask
	logic [3:0] scan_idx;
	logic [3:0] next_scan;

	// Next unmasked input after the current one
	always_comb begin
		next_scan = scan_idx;
		for (int k = NUM_ADC - 1; k >= 1; k--) begin
			if (!adc_cfg[16 + 4'(scan_idx + 4'(k))]) next_scan = 4'(scan_idx + 4'(k));
		end
	end

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) scan_idx <= 4'h0;
		else if (adc_cfg[4] && SEQ_STEP) scan_idx <= next_scan;
	end
	assign ADC_SEL = adc_cfg[4] ? scan_idx : adc_cfg[3:0];

	// ********************************************************
	// Read port
	// ********************************************************
	wire [31:0] stat = {6'h00, ~btn_s, 2'b00, pc_s, io_log, ph_val, gc_data};
	logic [31:0] rsel;
	always_comb begin
		if (hit(req.addr, REG_GC_CFG))        rsel = gc_cfg;
		else if (hit(req.addr, REG_GC_MASK))  rsel = gc_mask;
		else if (hit(req.addr, REG_PH_CFG))   rsel = ph_cfg;
		else if (hit(req.addr, REG_PC_MASK))  rsel = pc_mask;
		else if (hit(req.addr, REG_FAST_DAC)) rsel = {24'h0, fast_dac};
		else if (hit(req.addr, REG_LIM_DAC))  rsel = {22'h0, lim_dac};
		else if (hit(req.addr, REG_IO_DIR))   rsel = io_dir;
		else if (hit(req.addr, REG_IO_POL))   rsel = io_pol;
		else if (hit(req.addr, REG_IO_ROUTE)) rsel = io_route;
		else if (hit(req.addr, REG_IO_LINE))  rsel = io_line;
		else if (hit(req.addr, REG_IO_OUT))   rsel = io_out;
		else if (hit(req.addr, REG_IO_MASK))  rsel = io_mask;
		else if (hit(req.addr, REG_DATA_IN))  rsel = stat;
		else if (hit(req.addr, REG_PEND))     rsel = pend;
		else if (hit(req.addr, REG_CTRL))     rsel = ctrl;
		else if (hit(req.addr, REG_ADC))      rsel = {adc_cfg[31:16], 8'h0, scan_idx, adc_cfg[3:0]};
		else                                  rsel = 32'h0;
	end

	// Read data is held only in the cycle after a strobe
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) REG_RDATA <= 32'h0;
		else REG_RDATA <= req.rd ? rsel : 32'h0;
	end

endmodule
`default_nettype wire

// *** sim/aer_chk.sv ***
// Checker for the event routing block: timing relations seen at its ports.
// Assumes it is bound into aer_top and sees only that module's ports.
`timescale 1ns/10ps
`default_nettype none
module aer_chk
	import aer_pkg::*;
#(
	parameter longint LONG_PRESS = LONG_PRESS_CYC
) (
	input wire logic              REF_CLK,    // System clock
	input wire logic              RST_N,      // Async reset, active low
	input wire logic              REG_WR,     // Write strobe
	input wire logic              REG_RD,     // Read strobe
	input wire logic [31:0]       REG_RDATA,  // Read data
	input wire logic [NUM_GC-1:0] GC_RAW,     // General comparators
	input wire logic [NUM_PC-1:0] PC_RAW,     // Protection comparators
	input wire logic [NUM_IO-1:0] IO_I,       // Pin levels
	input wire logic [NUM_IO-1:0] IO_O,       // Pin drive value
	input wire logic              BTN_N,      // Push button
	input wire logic              HIBERNATE,  // Hibernate state
	input wire logic              BTN_WAKE,   // Wake request
	input wire logic              CPU_RESET,  // Long-press reset
	input wire logic              SEQ_STEP,   // Scan advance
	input wire logic [3:0]        ADC_SEL,    // Pre-selector input
	input wire logic              MAIN_IRQ,   // Main interrupt
	input wire logic              SECOND_IRQ, // Second interrupt
	input wire aer_prot_t         PROT_EV     // Protection events
);
	// ****************
	// Held-button counter
	// ****************
	longint low_cnt; // Raw cycles the button has been low
	// Counts raw cycles; the synchroniser lags, so the bounds carry slack
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N)
			low_cnt <= 0;
		else if (BTN_N)
			low_cnt <= 0;
		else
			low_cnt <= low_cnt + 1;
	end
	// ****************
	// Assertions
	// ****************
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (!RST_N);
	a_rdata_idle: assert property (!$past(REG_RD) |-> REG_RDATA == 32'h0)
		else $error("read data not zero outside answer cycle");
	a_pin_open_drain: assert property (IO_O == '0)
		else $error("pin drive value not low");
	a_event_two_cause: assert property (PROT_EV.two |-> $past(|PC_RAW, 2))
		else $error("event two without protection input");
	a_irq2_held: assert property ($fell(SECOND_IRQ) |-> $past(REG_WR))
		else $error("second interrupt dropped without a write");
	a_irq1_held: assert property ($fell(MAIN_IRQ) |-> $past(REG_WR))
		else $error("main interrupt dropped without a write");
	a_irq2_cause: assert property ($rose(SECOND_IRQ) |-> $past(REG_WR)
		|| $past(GC_RAW, 2) != $past(GC_RAW, 5) || $past(IO_I, 2) != $past(IO_I, 5))
		else $error("second interrupt without a cause");
	a_press_min: assert property ($rose(CPU_RESET) |-> low_cnt >= LONG_PRESS)
		else $error("processor reset before the long press");
	a_press_max: assert property ((low_cnt == LONG_PRESS + 6 && !HIBERNATE) |-> CPU_RESET)
		else $error("processor reset missing after long press");
	a_wake_hib: assert property (BTN_WAKE |-> HIBERNATE)
		else $error("wake request outside hibernate");
	a_adc_hold: assert property ((!SEQ_STEP && !REG_WR) |=> $stable(ADC_SEL))
		else $error("pre-selector moved without cause");
endmodule
bind aer_top aer_chk #(.LONG_PRESS(LONG_PRESS)) aer_chk_inst (.REF_CLK, .RST_N, .REG_WR,
	.REG_RD, .REG_RDATA, .GC_RAW, .PC_RAW, .IO_I, .IO_O, .BTN_N, .HIBERNATE, .BTN_WAKE,
	.CPU_RESET, .SEQ_STEP, .ADC_SEL, .MAIN_IRQ, .SECOND_IRQ, .PROT_EV);
`default_nettype wire

// *** sim/aer_host_model.sv ***
// Far-side model: interrupt controller and driver protection input.
// Assumes interrupt and event levels from the routing block, one clock.
`timescale 1ns/10ps
`default_nettype none
module aer_host_model
	import aer_pkg::*;
(
	input  wire logic       clk,        // System clock
	input  wire logic       rst_n,      // Async reset, active low
	input  wire logic       second_irq, // Second interrupt level
	input  wire aer_prot_t  prot_ev,    // Protection events
	output logic      [7:0] irq2_cnt,   // Interrupt entries taken
	output logic            tripped     // Driver protection latched
);
	logic irq2_q; // Previous level, so a held request counts once
	// Take requests on entry; the driver trips with no processor help
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irq2_q <= 1'b0;
			irq2_cnt <= 8'h00;
			tripped <= 1'b0;
		end else begin
			irq2_q <= second_irq;
			if (second_irq && !irq2_q)
				irq2_cnt <= irq2_cnt + 8'h01;
			if (prot_ev.one || prot_ev.two)
				tripped <= 1'b1;
		end
	end
endmodule
`default_nettype wire

// *** sim/testbench.sv ***
// Testbench: registers, edge interrupts, protection events, button, scan.
// Assumes package, design, checker and host model are compiled before it.
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import aer_pkg::*;
	localparam longint LP = 20; // Short long press keeps the run brief
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic [7:0]  addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [3:0]  gc = 4'h0;
	logic [5:0]  pc = 6'h00;
	logic [9:0]  io = 10'h000;
	logic        btn_n = 1'b1;
	logic        hib = 1'b0;
	logic        step = 1'b0;
	logic [31:0] rdata, d;
	logic [9:0]  lim;
	logic [7:0]  fast, n2;
	logic [3:0]  adc;
	logic        ab2, ab3, wake, hreq, cpu_rst, irq1, irq2, trip;
	aer_prot_t   ev;
	int          err_count = 0;
	int          cmp_count = 0;
	aer_top #(.LONG_PRESS(LP)) aer_top_inst (
		.REF_CLK(clk), .RST_N(rst_n), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr),
		.REG_RD(rd), .REG_RDATA(rdata), .GC_RAW(gc), .GC_REF_SEL(), .PH_RAW(3'h0),
		.PH_REF_SEL(), .PH_POS(), .PC_RAW(pc), .FAST_DAC_CODE(fast), .LIM_DAC_CODE(lim),
		.AB2_DAC_EN(ab2), .AB3_DAC_EN(ab3), .IO_I(io), .IO_O(), .IO_OE(), .DB_I(7'h00),
		.DB_O(), .DB_OE(), .BTN_N(btn_n), .HIBERNATE(hib), .BTN_WAKE(wake), .HIB_REQ(hreq),
		.CPU_RESET(cpu_rst), .SEQ_STEP(step), .ADC_SEL(adc), .MAIN_IRQ(irq1),
		.SECOND_IRQ(irq2), .PROT_EV(ev));
	aer_host_model aer_host_model_inst (.clk(clk), .rst_n(rst_n), .second_irq(irq2),
		.prot_ev(ev), .irq2_cnt(n2), .tripped(trip));
	// Free-running 10 MHz clock
	always #50 clk = ~clk;
	// ****************
	// Bus, wait and compare tasks
	// ****************
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic chf(input string n, input logic e, input logic g);
		chk(n, {31'h0, e}, {31'h0, g});
	endtask
	task automatic wreg(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= v;
		@(posedge clk);
		wr <= 1'b0;
		#1;
	endtask
	task automatic rreg(input logic [7:0] a, output logic [31:0] v);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 v = rdata;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic give_verdict();
		$display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// Watchdog sized well above the few hundred cycles the tests take
	initial begin
		#(5000 * 100);
		err_count++;
		give_verdict();
	end
	// ****************
	// Test sequence
	// ****************
	initial begin
		d = $urandom(32'hb4f0);
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		rreg(REG_CTRL, d);
		chk("ctrl reset", RST_ZERO, d);
		rreg(8'h40, d);
		chk("unmapped read", RST_ZERO, d);
		wreg(REG_CTRL, 32'h0000_0018);
		chf("dac on line 2", 1'b1, ab2);
		chf("dac on line 3", 1'b1, ab3);
		d = $urandom;
		wreg(REG_FAST_DAC, {24'h0, d[7:0]});
		wreg(REG_LIM_DAC, {22'h0, d[17:8]});
		chk("fast dac", {24'h0, d[7:0]}, {24'h0, fast});
		chk("limit dac", {22'h0, d[17:8]}, {22'h0, lim});
		$display("test registers done");
		// Each comparator rise raises, holds and clears; event one follows; masked fall stays quiet
		wreg(REG_CTRL, 32'h0000_0001);
		for (int i = 0; i < NUM_GC; i++) begin
			wreg(REG_GC_MASK, 32'h1 << i);
			wreg(REG_PEND, 32'hffff_ffff);
			@(posedge clk) gc[i] <= 1'b1;
			cyc(8);
			chf("irq2 on rise", 1'b1, irq2);
			chf("event one", 1'b1, ev.one);
			wreg(REG_PEND, 32'hffff_ffff);
			chf("irq2 cleared", 1'b0, irq2);
			@(posedge clk) gc[i] <= 1'b0;
			cyc(8);
			chf("masked fall", 1'b0, irq2);
		end
		chk("irq2 entries", NUM_GC, {24'h0, n2});
		$display("test comparator edges done");
		// Pins 6 to 9, alternating polarity; mask first so no stray edge fires
		for (int p = FIRST_IRQ_IO; p < FIRST_IRQ_IO + NUM_IRQ_IO; p++) begin
			wreg(REG_IO_MASK, 32'h1 << (p - FIRST_IRQ_IO + 4 * (p % 2)));
			wreg(REG_IO_POL, 32'(p % 2) << p);
			wreg(REG_PEND, 32'hffff_ffff);
			@(posedge clk) io[p] <= 1'b1;
			cyc(8);
			chf("pin edge irq2", 1'b1, irq2);
			@(posedge clk) io[p] <= 1'b0;
			wreg(REG_PEND, 32'hffff_ffff);
		end
		$display("test pin edges done");
		// Protection comparator masks: event two only, then all three
		wreg(REG_PC_MASK, 32'h0001_0000);
		wreg(REG_PEND, 32'hffff_ffff);
		@(posedge clk) pc[0] <= 1'b1;
		cyc(3);
		chk("events two only", 32'h2, {30'h0, ev});
		chf("main masked", 1'b0, irq1);
		rreg(REG_DATA_IN, d);
		chf("protection status", 1'b1, d[17]);
		wreg(REG_PC_MASK, 32'h0001_0101);
		chk("events both", 32'h3, {30'h0, ev});
		chf("main irq", 1'b1, irq1);
		chf("driver tripped", 1'b1, trip);
		@(posedge clk) pc[0] <= 1'b0;
		cyc(3);
		wreg(REG_PEND, 32'hffff_ffff);
		chf("main cleared", 1'b0, irq1);
		$display("test protection done");
		// Button: hibernate request, wake, then long press in normal run
		wreg(REG_CTRL, 32'h0000_0006);
		chf("hibernate request", 1'b1, hreq);
		@(posedge clk) hib <= 1'b1;
		btn_n <= 1'b0;
		cyc(6);
		chf("wake", 1'b1, wake);
		@(posedge clk) btn_n <= 1'b1;
		cyc(6);
		hib <= 1'b0;
		@(posedge clk) btn_n <= 1'b0;
		cyc(LP + 8);
		chf("long press reset", 1'b1, cpu_rst);
		@(posedge clk) btn_n <= 1'b1;
		cyc(6);
		chf("reset released", 1'b0, cpu_rst);
		$display("test button done");
		// Direct selection, then scan with even inputs masked
		d = $urandom;
		wreg(REG_ADC, {28'h0, d[3:0]});
		chk("direct select", {28'h0, d[3:0]}, {28'h0, adc});
		wreg(REG_ADC, 32'h5555_0010);
		repeat (5) begin
			@(posedge clk) step <= 1'b1;
			@(posedge clk) step <= 1'b0;
			#1 chf("scan skips masked", 1'b1, adc[0]);
		end
		$display("test pre-selector done");
		give_verdict();
	end
endmodule
`default_nettype wire
